// File: rtl/spc_device.sv
// spc_device: memory-side command pin front end with eight banks
// assumes the controller end on the same clk drives the pin interface
`timescale 1ns/10ps
`include "spc_regs.svh"

module spc_device (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// pins from the controller
	spc_pins_if.device       pins,
	// decoded command report
	output logic             cmd_valid,
	output logic [2:0]       cmd_code,
	output logic [2:0]       cmd_bank,
	output logic [14:0]      cmd_addr,
	// bank and power state
	output logic [7:0]       bank_open,
	output logic [1:0]       power_state,
	output logic             term_on,
	// write data out of the core side
	output logic             wr_valid,
	output logic [15:0]      wr_data,
	output logic [1:0]       wr_lane_en,
	// read data into the core side
	input  wire logic [15:0] rd_data,
	output logic             rd_take
);

	typedef struct packed {
		logic                  cke;
		logic                  cke_prev;
		logic                  cs_n;
		logic [2:0]            code;
		logic                  term_pin;
		logic [2:0]            ba;
		logic [14:0]           a;
		logic [1:0]            dm;
		logic [15:0]           dq;
		logic [1:0]            dqs;
		logic                  wbeat;
		spc_pkg::spc_pwr_type  pwr;
		logic [7:0]            open;
		logic [3:0][14:0]      mr;
		logic [3:0]            bcnt;
		logic                  bwr;
		logic [2:0]            bbank;
		logic                  bap;
		logic                  cmd_v;
		logic [2:0]            cmd_c;
		logic [2:0]            cmd_b;
		logic [14:0]           cmd_a;
		logic                  term;
		logic                  wr_v;
		logic [15:0]           wr_d;
		logic [1:0]            wr_en;
		logic                  rd_t;
		logic [15:0]           dq_o;
		logic                  dq_oe;
		logic [1:0]            dqs_o;
	} spc_dev_state_type;

	spc_dev_state_type q;
	spc_dev_state_type d;
	spc_pkg::spc_cmd_type cmd;

	assign cmd = spc_pkg::spc_cmd_type'(q.code);

	// termination is allowed when any termination field is nonzero
	function automatic logic term_allowed(input logic [14:0] mr1,
		input logic [14:0] mr2);
		term_allowed = mr1[`SPC_MODE1_TERM_A] | mr1[`SPC_MODE1_TERM_B] |
			mr1[`SPC_MODE1_TERM_C] | (|mr2[`SPC_MODE2_TERM_LSB +: 2]);
	endfunction : term_allowed

	// next-state logic: pin capture, decode, power and burst handling
	always_comb begin
		d       = q;
		d.cmd_v = 1'b0;
		d.wr_v  = 1'b0;
		d.wr_en = 2'h0;
		d.rd_t  = 1'b0;
		d.dq_oe = 1'b0;
		// clock enable and termination pins are sampled at every rising edge
		d.cke      = pins.cke;
		d.cke_prev = q.cke;
		d.term_pin = pins.termination_enable;
		d.wbeat    = pins.dq_c_oe;
		// buffers other than cke, reset, clock and termination are off unless run
		if (q.pwr == spc_pkg::PW_RUN) begin
			d.cs_n = pins.cs_n;
			d.code = {pins.ras_n, pins.cas_n, pins.we_n};
			d.ba   = pins.bank_select;
			d.a    = pins.addr;
			d.dm   = pins.byte_mask;
			d.dq   = pins.dq_bus;
			d.dqs  = pins.dqs_bus;
		end else begin
			d.cs_n  = 1'b1;
			d.wbeat = 1'b0;
		end
		// power state changes on clock enable
		case (q.pwr)
			spc_pkg::PW_RUN: begin
				if (q.cke_prev && !q.cke) begin
					if (!q.cs_n && cmd == spc_pkg::CMD_REF && q.open == 8'h00)
						d.pwr = spc_pkg::PW_SRF;
					else if (q.open == 8'h00)
						d.pwr = spc_pkg::PW_PPD;
					else
						d.pwr = spc_pkg::PW_APD;
				end
			end
			spc_pkg::PW_APD, spc_pkg::PW_PPD: begin
				if (q.cke)
					d.pwr = spc_pkg::PW_RUN;
			end
			spc_pkg::PW_SRF: begin
				// exit follows the pin itself, not its captured copy
				if (pins.cke)
					d.pwr = spc_pkg::PW_RUN;
			end
			default: d.pwr = spc_pkg::PW_RUN;
		endcase
		// command decode while running with clock enabled
		if (q.pwr == spc_pkg::PW_RUN && q.cke && q.cke_prev &&
			!q.cs_n) begin
			d.cmd_v = (cmd != spc_pkg::CMD_NOP);
			d.cmd_c = q.code;
			d.cmd_b = q.ba;
			d.cmd_a = q.a;
			case (cmd)
				spc_pkg::CMD_MODE: d.mr[q.ba[1:0]] = q.a;
				spc_pkg::CMD_ACT: d.open[q.ba] = 1'b1;
				spc_pkg::CMD_PRE: begin
					if (q.a[`SPC_AP_BIT])
						d.open = 8'h00;
					else
						d.open[q.ba] = 1'b0;
				end
				spc_pkg::CMD_RD, spc_pkg::CMD_WR: begin
					if (q.bcnt == 4'h0) begin
						d.bcnt  = spc_pkg::spc_burst_len(q.mr[0],
							q.a[`SPC_BC_BIT]);
						d.bwr   = (cmd == spc_pkg::CMD_WR);
						d.bbank = q.ba;
						d.bap   = q.a[`SPC_AP_BIT];
					end
				end
				default: d.cmd_v = d.cmd_v;
			endcase
		end
		// burst beats: writes take masked lanes, reads drive data
		if (q.bcnt != 4'h0 && q.pwr == spc_pkg::PW_RUN && q.cke) begin
			d.bcnt = q.bcnt - 4'h1;
			if (q.bwr) begin
				d.wr_v = q.wbeat;
				d.wr_d = q.dq;
				d.wr_en[0] = q.wbeat & q.dqs[0] & !q.dm[0];
				d.wr_en[1] = q.wbeat & q.dqs[1] & !q.dm[1];
			end else begin
				d.dq_oe = 1'b1;
				d.dq_o  = rd_data;
				d.dqs_o = ~q.dqs_o;
				d.rd_t  = 1'b1;
			end
			if (q.bcnt == 4'h1 && q.bap)
				d.open[q.bbank] = 1'b0;
		end
		// termination only when allowed and outside self-refresh
		d.term = q.term_pin && term_allowed(q.mr[1], q.mr[2]) &&
			(q.pwr != spc_pkg::PW_SRF);
		// device reset clears everything, stored modes included
		if (srst || !pins.device_reset_n)
			d = '0;
	end

	// state register
	always_ff @(posedge clk) begin
		q <= d;
	end

	// outputs straight from the state register
	assign cmd_valid    = q.cmd_v;
	assign cmd_code     = q.cmd_c;
	assign cmd_bank     = q.cmd_b;
	assign cmd_addr     = q.cmd_a;
	assign bank_open    = q.open;
	assign power_state  = q.pwr;
	assign term_on      = q.term;
	assign wr_valid     = q.wr_v;
	assign wr_data      = q.wr_d;
	assign wr_lane_en   = q.wr_en;
	assign rd_take      = q.rd_t;
	assign pins.dq_d    = q.dq_o;
	assign pins.dq_d_oe = q.dq_oe;
	assign pins.dqs_d   = q.dqs_o;

endmodule : spc_device

// File: shared/spc_regs.svh
// spc_regs.svh: offsets, field positions and counts for the pin interface
// assumes inclusion by the spc package and the two end modules
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// controller register byte offsets
`define SPC_OFS_CMD     5'h00
`define SPC_OFS_ADDR    5'h04
`define SPC_OFS_CTRL    5'h08
`define SPC_OFS_WDATA   5'h0c
`define SPC_OFS_STATUS  5'h10
`define SPC_OFS_RDATA   5'h14

// control register bits
`define SPC_CTRL_CKE    0
`define SPC_CTRL_TERM   1
`define SPC_CTRL_RST    2

// command register: refresh with this bit set also drops clock enable
`define SPC_CMD_SLEEP_BIT 6

// mode register fields
`define SPC_MR0_BL_LSB  0
`define SPC_MR0_BL_OTF  2'h1
`define SPC_MR0_BL_BC4  2'h2
`define SPC_MODE1_TERM_A   2
`define SPC_MODE1_TERM_B   6
`define SPC_MODE1_TERM_C   9
`define SPC_MODE2_TERM_LSB 9
`define SPC_AP_BIT      10
`define SPC_BC_BIT      12

// burst lengths and guard cycles
`define SPC_BL_FULL     4'h8
`define SPC_BL_CHOP     4'h4
`define SPC_BUSY_EXTRA  4'h4

`endif

// File: shared/spc_pkg.sv
// spc_pkg: types and shared decoding for the pin command interface
// assumes spc_regs.svh is on the include path
`include "spc_regs.svh"
package spc_pkg;

	// command code from ras_n, cas_n, we_n with chip select low
	typedef enum logic [2:0] {
		CMD_MODE = 3'h0,
		CMD_REF = 3'h1,
		CMD_PRE = 3'h2,
		CMD_ACT = 3'h3,
		CMD_WR  = 3'h4,
		CMD_RD  = 3'h5,
		CMD_ZQ  = 3'h6,
		CMD_NOP = 3'h7
	} spc_cmd_type;

	// device power state
	typedef enum logic [1:0] {
		PW_RUN = 2'h0,
		PW_APD = 2'h1,
		PW_PPD = 2'h2,
		PW_SRF = 2'h3
	} spc_pwr_type;

	// burst length from mode register zero and the chop pin
	function automatic logic [3:0] spc_burst_len(input logic [14:0] mr0,
		input logic chop_n);
		logic [1:0] bl;
		bl = mr0[`SPC_MR0_BL_LSB +: 2];
		if (bl == `SPC_MR0_BL_OTF)
			spc_burst_len = chop_n ? `SPC_BL_FULL : `SPC_BL_CHOP;
		else if (bl == `SPC_MR0_BL_BC4)
			spc_burst_len = `SPC_BL_CHOP;
		else
			spc_burst_len = `SPC_BL_FULL;
	endfunction : spc_burst_len

endpackage : spc_pkg

// File: shared/spc_pins_if.sv
// spc_pins_if: command, address, control and data pins between the ends
// assumes both ends share clk; data pins are resolved here from enables
`timescale 1ns/10ps
interface spc_pins_if (
	input wire logic clk
);
	logic        cke;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic        termination_enable;
	logic        device_reset_n;
	logic [2:0]  bank_select;
	logic [14:0] addr;
	logic [1:0]  byte_mask;
	logic [15:0] dq_c;
	logic        dq_c_oe;
	logic [1:0]  dqs_c;
	logic [15:0] dq_d;
	logic        dq_d_oe;
	logic [1:0]  dqs_d;
	logic [15:0] dq_bus;
	logic [1:0]  dqs_bus;

	// wire level of the shared data and strobe lines
	assign dq_bus  = dq_c_oe ? dq_c : (dq_d_oe ? dq_d : 16'h0000);
	assign dqs_bus = dq_c_oe ? dqs_c : (dq_d_oe ? dqs_d : 2'h0);

	modport device (
		input  cke, cs_n, ras_n, cas_n, we_n, termination_enable,
		input  device_reset_n, bank_select, addr, byte_mask,
		input  dq_bus, dqs_bus, dq_c_oe,
		output dq_d, dq_d_oe, dqs_d
	);
	modport ctrl (
		input  dq_bus, dq_d_oe,
		output cke, cs_n, ras_n, cas_n, we_n, termination_enable,
		output device_reset_n, bank_select, addr, byte_mask,
		output dq_c, dq_c_oe, dqs_c
	);
endinterface : spc_pins_if

// File: rtl/spc_ctrl.sv
// spc_ctrl: controller end, drives the pins from Avalon-MM registers
// assumes an Avalon-MM master on clk with byte addresses
`timescale 1ns/10ps
`include "spc_regs.svh"
module spc_ctrl (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Avalon-MM slave
	input  wire logic [4:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// pins to the device
	spc_pins_if.ctrl         pins
);

	typedef struct packed {
		logic        wait_n;
		logic [31:0] rdata_bus;
		logic [2:0]  ctrl;
		logic [14:0] addr_r;
		logic [17:0] wdata;
		logic [14:0] mr0;
		logic [3:0]  busy;
		logic [3:0]  wcnt;
		logic [15:0] rdata;
		logic [7:0]  rcount;
		logic        cs_n;
		logic [2:0]  code;
		logic [2:0]  ba;
		logic [14:0] a;
		logic        cke;
		logic        dq_oe;
	} spc_ctl_state_type;

	spc_ctl_state_type q;
	spc_ctl_state_type d;
	logic              acc;
	logic              cmd_hit;
	logic [3:0]        bl;

	assign acc     = avs_read ^ avs_write;
	assign cmd_hit = avs_write && avs_address == `SPC_OFS_CMD;
	assign bl      = spc_pkg::spc_burst_len(q.mr0, q.addr_r[`SPC_BC_BIT]);

	// next-state logic: bus slave, command launch and data beats
	always_comb begin
		d        = q;
		d.wait_n = 1'b0;
		d.cs_n   = 1'b1;
		d.code   = spc_pkg::CMD_NOP;
		d.dq_oe  = 1'b0;
		// answer one cycle after the request, command held off while busy
		if (acc && !q.wait_n && !(cmd_hit && q.busy != 4'h0)) begin
			d.wait_n = 1'b1;
			case (avs_address)
				`SPC_OFS_CTRL:   d.rdata_bus = {29'h0, q.ctrl};
				`SPC_OFS_ADDR:   d.rdata_bus = {17'h0, q.addr_r};
				`SPC_OFS_WDATA:  d.rdata_bus = {14'h0, q.wdata};
				`SPC_OFS_STATUS: d.rdata_bus = {20'h0, q.rcount, q.busy};
				`SPC_OFS_RDATA:  d.rdata_bus = {16'h0, q.rdata};
				default:         d.rdata_bus = 32'h0;
			endcase
		end
		// a write takes effect on the edge where waitrequest is low
		if (avs_write && q.wait_n) begin
			case (avs_address)
				`SPC_OFS_CTRL:  d.ctrl   = avs_writedata[2:0];
				`SPC_OFS_ADDR:  d.addr_r = avs_writedata[14:0];
				`SPC_OFS_WDATA: d.wdata  = avs_writedata[17:0];
				`SPC_OFS_CMD: begin
					d.cs_n = 1'b0;
					d.code = avs_writedata[2:0];
					d.ba   = avs_writedata[5:3];
					d.a    = q.addr_r;
					if (avs_writedata[2:0] == spc_pkg::CMD_MODE &&
						avs_writedata[5:3] == 3'h0)
						d.mr0 = q.addr_r;
					// refresh with the sleep bit drops cke in the same cycle
					if (avs_writedata[2:0] == spc_pkg::CMD_REF &&
						avs_writedata[`SPC_CMD_SLEEP_BIT])
						d.ctrl[`SPC_CTRL_CKE] = 1'b0;
					if (avs_writedata[2:0] == spc_pkg::CMD_WR)
						d.wcnt = bl;
					if (avs_writedata[2:0] == spc_pkg::CMD_WR ||
						avs_writedata[2:0] == spc_pkg::CMD_RD)
						d.busy = bl + `SPC_BUSY_EXTRA;
				end
				default: d.ctrl = q.ctrl;
			endcase
		end
		// write beats follow the command, strobe held high with each word
		if (q.wcnt != 4'h0) begin
			d.wcnt  = q.wcnt - 4'h1;
			d.dq_oe = 1'b1;
		end
		if (q.busy != 4'h0)
			d.busy = q.busy - 4'h1;
		// device reset wipes its modes, so the burst shadow goes too
		if (q.ctrl[`SPC_CTRL_RST])
			d.mr0 = 15'h0000;
		// clock enable follows the register at once, high during access
		d.cke = d.ctrl[`SPC_CTRL_CKE] | (d.busy != 4'h0);
		// read words arrive with the device data enable
		if (pins.dq_d_oe) begin
			d.rdata  = pins.dq_bus;
			d.rcount = q.rcount + 8'h01;
		end
		if (srst)
			d = '0;
	end

	// state register
	always_ff @(posedge clk) begin
		q <= d;
	end

	// outputs straight from the state register
	assign avs_readdata            = q.rdata_bus;
	assign avs_waitrequest         = !q.wait_n;
	assign pins.cke                = q.cke;
	assign pins.cs_n               = q.cs_n;
	assign pins.ras_n              = q.code[2];
	assign pins.cas_n              = q.code[1];
	assign pins.we_n               = q.code[0];
	assign pins.termination_enable = q.ctrl[`SPC_CTRL_TERM];
	assign pins.device_reset_n     = !q.ctrl[`SPC_CTRL_RST];
	assign pins.bank_select        = q.ba;
	assign pins.addr               = q.a;
	assign pins.byte_mask          = q.wdata[17:16];
	assign pins.dq_c               = q.wdata[15:0];
	assign pins.dq_c_oe            = q.dq_oe;
	assign pins.dqs_c              = {q.dq_oe, q.dq_oe};

endmodule : spc_ctrl

// File: testbench/spc_pins_chk.sv
// spc_pins_chk: assertions on the pins between the two ends
// assumes one clock and srst shared by both ends
`timescale 1ns/10ps
module spc_pins_chk (
	// clock and reset
	input wire logic       clk,
	input wire logic       srst,
	// command and control pins
	input wire logic       cke,
	input wire logic       cs_n,
	input wire logic       ras_n,
	input wire logic       cas_n,
	input wire logic       we_n,
	input wire logic       device_reset_n,
	// data enables and strobes
	input wire logic       dq_c_oe,
	input wire logic [1:0] dqs_c,
	input wire logic       dq_d_oe,
	input wire logic [1:0] dqs_d
);
	logic wr_c;
	logic rd_c;
	logic act_c;

	// decoded commands while selected
	assign wr_c  = !cs_n && {ras_n, cas_n, we_n} == 3'h4;
	assign rd_c  = !cs_n && {ras_n, cas_n, we_n} == 3'h5;
	assign act_c = !cs_n && {ras_n, cas_n, we_n} == 3'h3;

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	property p_cmd_one; !cs_n |=> cs_n; endproperty
	a_cmd_one: assert property (p_cmd_one)
		else $error("command held past one cycle");
	property p_wr_beats; wr_c |=> dq_c_oe [*4]; endproperty
	a_wr_beats: assert property (p_wr_beats)
		else $error("write burst too short");
	property p_wr_start; $rose(dq_c_oe) |-> $past(wr_c); endproperty
	a_wr_start: assert property (p_wr_start)
		else $error("write data without write command");
	property p_strobe_c; dq_c_oe |-> dqs_c == 2'h3; endproperty
	a_strobe_c: assert property (p_strobe_c)
		else $error("write strobe not with data");
	property p_cke_hold; (dq_c_oe || dq_d_oe) |-> cke; endproperty
	a_cke_hold: assert property (p_cke_hold)
		else $error("clock enable low in access");
	property p_one_drv; !(dq_c_oe && dq_d_oe); endproperty
	a_one_drv: assert property (p_one_drv)
		else $error("both ends drive data");
	property p_rd_beats;
		(cke && device_reset_n) [*3] ##0 rd_c |-> ##3 dq_d_oe [*4];
	endproperty
	a_rd_beats: assert property (p_rd_beats)
		else $error("read burst missing");
	property p_rd_start; $rose(dq_d_oe) |-> $past(rd_c, 3); endproperty
	a_rd_start: assert property (p_rd_start)
		else $error("read data without read command");
	property p_rd_strobe;
		dq_d_oe && $past(dq_d_oe) |-> dqs_d != $past(dqs_d);
	endproperty
	a_rd_strobe: assert property (p_rd_strobe)
		else $error("read strobe did not toggle");
	property p_dev_rst; !device_reset_n |=> !dq_d_oe; endproperty
	a_dev_rst: assert property (p_dev_rst)
		else $error("device drives in reset");

	// main scenarios
	c_wr: cover property (wr_c);
	c_rd: cover property (rd_c);
	c_act: cover property (act_c);
endmodule : spc_pins_chk

// File: testbench/tb_sdram_pin_command_interface.sv
// tb_sdram_pin_command_interface: drives the controller registers
// assumes both ends face each other through spc_pins_if on one clock
`timescale 1ns/10ps
`include "spc_regs.svh"
module tb_sdram_pin_command_interface;
	logic        clk, srst, avs_read, avs_write, avs_waitrequest;
	logic [4:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata, rdv;
	logic [15:0] rd_data, wr_data, data_seen;
	logic        cmd_valid, term_on, wr_valid, rd_take;
	logic [2:0]  cmd_code, cmd_bank;
	logic [14:0] cmd_addr;
	logic [7:0]  bank_open;
	logic [1:0]  power_state, wr_lane_en, lane_seen;
	int          fails, tests_run, wr_beats, rd_beats;

	spc_pins_if pins (.clk(clk));
	spc_ctrl i_spc_ctrl (.clk(clk), .srst(srst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pins(pins.ctrl));
	spc_device i_spc_device (.clk(clk), .srst(srst), .pins(pins.device),
		.cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
		.cmd_addr(cmd_addr), .bank_open(bank_open),
		.power_state(power_state), .term_on(term_on), .wr_valid(wr_valid),
		.wr_data(wr_data), .wr_lane_en(wr_lane_en), .rd_data(rd_data),
		.rd_take(rd_take));
	spc_pins_chk i_spc_pins_chk (.clk(clk), .srst(srst), .cke(pins.cke),
		.cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n),
		.we_n(pins.we_n), .device_reset_n(pins.device_reset_n),
		.dq_c_oe(pins.dq_c_oe), .dqs_c(pins.dqs_c),
		.dq_d_oe(pins.dq_d_oe), .dqs_d(pins.dqs_d));

	// 10 MHz clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// count core side beats and keep the last write lane and data
	always @(posedge clk) begin
		if (wr_valid) begin
			wr_beats  <= wr_beats + 1;
			lane_seen <= wr_lane_en;
			data_seen <= wr_data;
		end
		if (rd_take)
			rd_beats <= rd_beats + 1;
	end

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic lim(input int n, input int m);
		if (n >= m) begin
			fails++;
			end_sim();
		end
	endtask : lim

	// one Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		avs_address   <= a;
		avs_write     <= wr;
		avs_read      <= !wr;
		avs_writedata <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 200);
		rdv = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		lim((avs_waitrequest !== 1'b0) ? n : 0, 200);
	endtask : bus

	// issue a command, judge its decode, then wait until not busy
	task automatic issue(input logic [2:0] code, input logic [2:0] bank,
		input logic [14:0] a, input logic exp);
		int n;
		logic seen;
		bus(1'b1, `SPC_OFS_ADDR, {17'h0, a});
		bus(1'b1, `SPC_OFS_CMD, {26'h0, bank, code});
		seen = 1'b0;
		for (n = 0; n < 8; n++) begin
			@(posedge clk);
			if (cmd_valid === 1'b1)
				seen = 1'b1;
		end
		chk(seen, exp);
		if (exp)
			chk({cmd_code, cmd_bank, cmd_addr}, {code, bank, a});
		n = 0;
		do begin
			bus(1'b0, `SPC_OFS_STATUS, 32'h0);
			n++;
		end while (rdv[3:0] !== 4'h0 && n < 30);
		lim((rdv[3:0] !== 4'h0) ? n : 0, 30);
	endtask : issue

	// power-down kinds and commands ignored with clock enable low
	task automatic t_pwr();
		bus(1'b0, 5'h1c, 32'h0);
		chk(rdv, 32'h0);
		bus(1'b1, `SPC_OFS_CTRL, 32'h1);
		bus(1'b1, `SPC_OFS_CTRL, 32'h0);
		issue(3'h3, 3'h1, 15'h0, 1'b0);
		chk(power_state, 2'h2);
		bus(1'b1, `SPC_OFS_CTRL, 32'h1);
		issue(3'h3, 3'h5, 15'h1234, 1'b1);
		chk(bank_open, 8'h20);
		bus(1'b1, `SPC_OFS_CTRL, 32'h0);
		bus(1'b0, `SPC_OFS_STATUS, 32'h0);
		chk(power_state, 2'h1);
		bus(1'b1, `SPC_OFS_CTRL, 32'h1);
	endtask : t_pwr

	// termination only once a mode register allows it
	task automatic t_odt();
		bus(1'b1, `SPC_OFS_CTRL, 32'h3);
		bus(1'b0, `SPC_OFS_STATUS, 32'h0);
		chk(term_on, 1'b0);
		issue(3'h0, 3'h1, 15'h0004, 1'b1);
		chk(term_on, 1'b1);
		bus(1'b1, `SPC_OFS_CTRL, 32'h1);
		bus(1'b0, `SPC_OFS_STATUS, 32'h0);
		chk(term_on, 1'b0);
	endtask : t_odt

	task automatic wr_n(input logic [14:0] a, input int exp);
		wr_beats = 0;
		issue(3'h4, 3'h5, a, 1'b1);
		chk(wr_beats, exp);
	endtask : wr_n

	// byte masks and burst chop on writes
	task automatic t_wr();
		bus(1'b1, `SPC_OFS_WDATA, 32'h1beef);
		bus(1'b0, `SPC_OFS_WDATA, 32'h0);
		chk(rdv, 32'h1beef);
		wr_n(15'h0000, 8);
		chk({lane_seen, data_seen}, {2'h2, 16'hbeef});
		issue(3'h0, 3'h0, 15'h0001, 1'b1);
		bus(1'b1, `SPC_OFS_WDATA, 32'h25a5a);
		wr_n(15'h0000, 4);
		chk({lane_seen, data_seen}, {2'h1, 16'h5a5a});
		wr_n(15'h1000, 8);
	endtask : t_wr

	// read with auto precharge, then single and all bank precharge
	task automatic t_rd();
		rd_beats = 0;
		issue(3'h5, 3'h5, 15'h1400, 1'b1);
		chk(rd_beats, 8);
		chk(rdv[11:4], 8'h08);
		chk(bank_open, 8'h00);
		bus(1'b0, `SPC_OFS_RDATA, 32'h0);
		chk(rdv[15:0], 16'hc3a5);
		issue(3'h3, 3'h2, 15'h0, 1'b1);
		issue(3'h3, 3'h6, 15'h0, 1'b1);
		issue(3'h2, 3'h2, 15'h0, 1'b1);
		chk(bank_open, 8'h40);
		issue(3'h2, 3'h0, 15'h0400, 1'b1);
		chk(bank_open, 8'h00);
	endtask : t_rd

	// self-refresh: entered by refresh with cke falling, left on the pin
	task automatic t_srf();
		bus(1'b1, `SPC_OFS_CTRL, 32'h3);
		bus(1'b0, `SPC_OFS_STATUS, 32'h0);
		chk(term_on, 1'b1);
		bus(1'b1, `SPC_OFS_CMD, 32'h41);
		repeat (2) bus(1'b0, `SPC_OFS_STATUS, 32'h0);
		chk(power_state, 2'h3);
		chk(term_on, 1'b0);
		bus(1'b1, `SPC_OFS_CTRL, 32'h1);
		repeat (2) @(posedge clk);
		chk(power_state, 2'h0);
	endtask : t_srf

	// device reset clears banks and mode registers
	task automatic t_rst();
		issue(3'h3, 3'h3, 15'h0, 1'b1);
		bus(1'b1, `SPC_OFS_CTRL, 32'h5);
		bus(1'b1, `SPC_OFS_CTRL, 32'h1);
		chk(bank_open, 8'h00);
		for (int c = 1; c < 7; c += 5)
			issue(c[2:0], 3'h0, 15'h0, 1'b1);
		issue(3'h3, 3'h5, 15'h0, 1'b1);
		wr_n(15'h0000, 8);
	endtask : t_rst

	// reset, then the scenarios
	initial begin
		srst = 1'b1;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		rd_data = 16'hc3a5;
		fails = 0;
		tests_run = 0;
		wr_beats = 0;
		rd_beats = 0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		t_pwr();
		t_odt();
		t_wr();
		t_rd();
		t_srf();
		t_rst();
		end_sim();
	end
endmodule : tb_sdram_pin_command_interface
